// ==== inc/tbr_pkg.sv ====
package tbr_pkg;

	// ----------------------------------------
	// Register space decode
	// ----------------------------------------
	localparam logic [7:0] PTR_ADDR = 8'hFD;   // Pointer register address
	localparam logic [3:0] BANK_NORMAL = 4'h0; // Normal register file
	localparam logic [3:0] BANK_TIMER = 4'hD;  // Timer bank
	localparam logic [3:0] BANK_F = 4'hF;      // Bank served elsewhere
	localparam logic [3:0] GROUP_LOW = 4'h0;   // Group swapped by banks

	// ----------------------------------------
	// Offsets inside the timer bank
	// ----------------------------------------
	localparam logic [3:0] OFS_CTL = 4'h0;
	localparam logic [3:0] OFS_RSVD = 4'h3;
	localparam logic [3:0] OFS_T8_LO_HOLD = 4'h4;
	localparam logic [3:0] OFS_T8_HI_HOLD = 4'h5;
	localparam logic [3:0] OFS_T16_LO_HOLD = 4'h6;
	localparam logic [3:0] OFS_T16_HI_HOLD = 4'h7;
	localparam logic [3:0] OFS_T16_CAP_LO = 4'h8;
	localparam logic [3:0] OFS_T16_CAP_HI = 4'h9;
	localparam logic [3:0] OFS_T8_CAP_LO = 4'hA;
	localparam logic [3:0] OFS_T8_CAP_HI = 4'hB;

	// ----------------------------------------
	// Control register fields
	// ----------------------------------------
	localparam int CTL_RUN = 7;     // Timer run
	localparam int CTL_SINGLE = 6;  // Single pass
	localparam int CTL_TOUT = 5;    // Time-out flag
	localparam int CTL_PRE_HI = 4;  // Prescale code, upper bit
	localparam int CTL_PRE_LO = 3;  // Prescale code, lower bit
	localparam int CTL_CAP_IE = 2;  // Capture interrupt enable
	localparam int CTL_TOUT_IE = 1; // Time-out interrupt enable
	localparam int CTL_PIN_SEL = 0; // Shared pin source

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] CTL_RST = 8'h00;
	localparam logic [7:0] HOLD_RST = 8'h00;
	localparam logic [7:0] CAP_RST = 8'h00;
	localparam logic [7:0] PTR_RST = 8'h00;
	localparam logic [7:0] RSVD_VAL = 8'h00;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	// One register access from the processor side
	typedef struct packed {
		logic wr;
		logic rd;
		logic short_addr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} tbr_req_s;

	// Prescale code to divider terminal value (divide 1, 2, 4, 8)
	function automatic logic [2:0] pre_last(input logic [1:0] code);
		case (code)
			2'h0: pre_last = 3'h0;
			2'h1: pre_last = 3'h1;
			2'h2: pre_last = 3'h3;
			default: pre_last = 3'h7;
		endcase
	endfunction

endpackage

// ==== logic/tbr_timer8.sv ====
`timescale 1ns/1ps

// Eight-bit two-level down counter with prescaler
module tbr_timer8 (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	// Control
	input wire logic run_i,
	input wire logic single_i,
	input wire logic [1:0] prescale_i,
	input wire logic [7:0] hi_hold_i,
	input wire logic [7:0] lo_hold_i,
	// Status
	output logic [7:0] count_o,
	output logic level_o,
	output logic tc_o
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [2:0] pre;  // Prescale count
		logic [7:0] cnt;  // Down counter
		logic level;      // Current output level
		logic loaded;     // First load done
		logic tc;         // Terminal count pulse
	} tbr_t8_s;

	tbr_t8_s st_reg;
	tbr_t8_s st_next;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		st_next = st_reg;
		st_next.tc = 1'b0;
		// Stopped: restart cleanly on next enable
		if (!run_i)
		begin
			st_next.pre = 3'h0;
			st_next.loaded = 1'b0;
			st_next.level = 1'b0;
		end
		// First cycle of a run loads the high count
		else if (!st_reg.loaded)
		begin
			st_next.loaded = 1'b1;
			st_next.level = 1'b1;
			st_next.cnt = hi_hold_i;
		end
		// Prescaler tick
		else if (st_reg.pre == tbr_pkg::pre_last(prescale_i))
		begin
			st_next.pre = 3'h0;
			if (st_reg.cnt == 8'h00)
			begin
				// Terminal count: swap level, reload other hold
				st_next.tc = 1'b1;
				st_next.level = ~st_reg.level;
				st_next.cnt = st_reg.level ? lo_hold_i : hi_hold_i;
				// Single pass freezes until run is rewritten
				if (single_i)
				begin
					st_next.loaded = 1'b0;
				end
			end
			else
			begin
				st_next.cnt = st_reg.cnt - 8'h01;
			end
		end
		else
		begin
			st_next.pre = st_reg.pre + 3'h1;
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			st_reg <= '0;
		end
		else if (ce_i)
		begin
			st_reg <= st_next;
		end
	end

	assign count_o = st_reg.cnt;
	assign level_o = st_reg.level;
	assign tc_o = st_reg.tc;

endmodule

// ==== logic/tbr_bank.sv ====
`timescale 1ns/1ps

module tbr_bank (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	// Register access
	input wire tbr_pkg::tbr_req_s req_i,
	output logic [7:0] rdata_o,
	output logic hit_o,
	// Demodulation input
	input wire logic demod_mode_i,
	input wire logic demod_pin_i,
	// Shared output pin
	input wire logic port_out_i,
	output logic shared_pin_o,
	// Interrupt requests
	output logic tout_irq_o,
	output logic cap_irq_o
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] ptr;       // bank_group_pointer
		logic [7:0] ctl;       // timer8_control
		logic [7:0] t8_lo;     // timer8_low_level_hold
		logic [7:0] t8_hi;     // timer8_high_level_hold
		logic [7:0] t16_lo;    // timer16_low_byte_hold
		logic [7:0] t16_hi;    // timer16_high_byte_hold
		logic [7:0] c16_lo;    // timer16_capture_low_byte
		logic [7:0] c16_hi;    // timer16_capture_high_byte
		logic [7:0] c8_lo;     // timer8_capture_low_level
		logic [7:0] c8_hi;     // timer8_capture_high_level
		logic [15:0] cnt16;    // Edge-to-edge interval count
		logic sync1;           // Pin synchroniser, first stage
		logic sync2;           // Pin synchroniser, second stage
		logic dprev;           // Previous synchronised level
		logic [7:0] rdata;     // Read data
		logic hit;             // Access claimed by this block
		logic pin;             // Shared pin level
		logic tout_irq;        // Time-out interrupt pulse
		logic cap_irq;         // Capture interrupt pulse
	} tbr_bank_s;

	tbr_bank_s st_reg;
	tbr_bank_s st_next;

	// Timer engine status
	logic [7:0] t8_count;
	logic t8_level;
	logic t8_tc;

	// Decode results
	logic [7:0] eff_addr;
	logic in_bank;
	logic claimed;
	logic ptr_sel;

	// Edge events
	logic rise;
	logic fall;
	logic ctl_wr;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	// Short form takes its group from the pointer upper nibble
	function automatic logic [7:0] eff_of(input tbr_pkg::tbr_req_s r,
		input logic [7:0] p);
		eff_of = r.short_addr ? {p[7:4], r.addr[3:0]} : r.addr;
	endfunction

	// True when the timer bank register at an offset is addressed
	function automatic logic sel_ofs(input logic [3:0] ofs,
		input logic b, input logic [7:0] a);
		sel_ofs = b && (a[3:0] == ofs);
	endfunction

	always_comb
	begin
		eff_addr = eff_of(req_i, st_reg.ptr);
		ptr_sel = (eff_addr == tbr_pkg::PTR_ADDR);
		// Low group swapped only for a bank other than 0 and F
		claimed = (eff_addr[7:4] == tbr_pkg::GROUP_LOW)
			&& (st_reg.ptr[3:0] != tbr_pkg::BANK_NORMAL)
			&& (st_reg.ptr[3:0] != tbr_pkg::BANK_F);
		in_bank = claimed && (st_reg.ptr[3:0] == tbr_pkg::BANK_TIMER);
	end

	// ----------------------------------------
	// Timer engine
	// ----------------------------------------
	tbr_timer8 tbr_timer8_inst (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.ce_i(ce_i),
		.run_i(st_reg.ctl[tbr_pkg::CTL_RUN]),
		.single_i(st_reg.ctl[tbr_pkg::CTL_SINGLE]),
		.prescale_i(st_reg.ctl[tbr_pkg::CTL_PRE_HI:tbr_pkg::CTL_PRE_LO]),
		.hi_hold_i(st_reg.t8_hi),
		.lo_hold_i(st_reg.t8_lo),
		.count_o(t8_count),
		.level_o(t8_level),
		.tc_o(t8_tc)
	);

	// ----------------------------------------
	// Edge detect on the synchronised pin
	// ----------------------------------------
	always_comb
	begin
		rise = demod_mode_i && st_reg.sync2 && !st_reg.dprev;
		fall = demod_mode_i && !st_reg.sync2 && st_reg.dprev;
		ctl_wr = req_i.wr && sel_ofs(tbr_pkg::OFS_CTL, in_bank, eff_addr);
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		st_next = st_reg;
		st_next.tout_irq = 1'b0;
		st_next.cap_irq = 1'b0;

		// Two-stage pin synchroniser
		st_next.sync1 = demod_pin_i;
		st_next.sync2 = st_reg.sync1;
		st_next.dprev = st_reg.sync2;

		// Interval counter restarts at every edge
		if (!demod_mode_i || rise || fall)
		begin
			st_next.cnt16 = 16'h0000;
		end
		else
		begin
			st_next.cnt16 = st_reg.cnt16 + 16'h0001;
		end

		// Rising edge ends a low phase
		if (rise)
		begin
			st_next.c8_lo = t8_count;
		end
		// Falling edge ends a high phase
		if (fall)
		begin
			st_next.c8_hi = t8_count;
		end
		// Interval split across two bytes on any edge
		if (rise || fall)
		begin
			st_next.c16_lo = st_reg.cnt16[7:0];
			st_next.c16_hi = st_reg.cnt16[15:8];
			st_next.cap_irq = st_reg.ctl[tbr_pkg::CTL_CAP_IE];
		end

		// Software writes
		if (req_i.wr)
		begin
			if (ptr_sel)
			begin
				st_next.ptr = req_i.wdata;
			end
			else if (in_bank)
			begin
				case (eff_addr[3:0])
					tbr_pkg::OFS_CTL:
					begin
						// All but the flag copy straight in
						st_next.ctl = req_i.wdata;
						st_next.ctl[tbr_pkg::CTL_TOUT] =
							st_reg.ctl[tbr_pkg::CTL_TOUT]
							& ~req_i.wdata[tbr_pkg::CTL_TOUT];
					end
					tbr_pkg::OFS_T8_LO_HOLD: st_next.t8_lo = req_i.wdata;
					tbr_pkg::OFS_T8_HI_HOLD: st_next.t8_hi = req_i.wdata;
					tbr_pkg::OFS_T16_LO_HOLD: st_next.t16_lo = req_i.wdata;
					tbr_pkg::OFS_T16_HI_HOLD: st_next.t16_hi = req_i.wdata;
					// Captures and reserved slot ignore writes
					default: st_next.t8_lo = st_next.t8_lo;
				endcase
			end
		end

		// Terminal count, applied after the write so set wins
		if (t8_tc)
		begin
			st_next.ctl[tbr_pkg::CTL_TOUT] = 1'b1;
			st_next.tout_irq = st_reg.ctl[tbr_pkg::CTL_TOUT_IE];
			// Single pass stops: run bit reads back the stop
			if (st_reg.ctl[tbr_pkg::CTL_SINGLE] && !ctl_wr)
			begin
				st_next.ctl[tbr_pkg::CTL_RUN] = 1'b0;
			end
		end

		// Read data, registered one cycle after the request
		st_next.hit = (req_i.rd || req_i.wr) && (ptr_sel || claimed);
		if (req_i.rd)
		begin
			st_next.rdata = 8'h00;
			if (ptr_sel)
			begin
				st_next.rdata = st_reg.ptr;
			end
			else if (in_bank)
			begin
				case (eff_addr[3:0])
					tbr_pkg::OFS_CTL: st_next.rdata = st_reg.ctl;
					tbr_pkg::OFS_RSVD: st_next.rdata = tbr_pkg::RSVD_VAL;
					tbr_pkg::OFS_T8_LO_HOLD: st_next.rdata = st_reg.t8_lo;
					tbr_pkg::OFS_T8_HI_HOLD: st_next.rdata = st_reg.t8_hi;
					tbr_pkg::OFS_T16_LO_HOLD: st_next.rdata = st_reg.t16_lo;
					tbr_pkg::OFS_T16_HI_HOLD: st_next.rdata = st_reg.t16_hi;
					tbr_pkg::OFS_T16_CAP_LO: st_next.rdata = st_reg.c16_lo;
					tbr_pkg::OFS_T16_CAP_HI: st_next.rdata = st_reg.c16_hi;
					tbr_pkg::OFS_T8_CAP_LO: st_next.rdata = st_reg.c8_lo;
					tbr_pkg::OFS_T8_CAP_HI: st_next.rdata = st_reg.c8_hi;
					// Registers owned by other blocks read zero here
					default: st_next.rdata = 8'h00;
				endcase
			end
		end

		// Shared pin source
		st_next.pin = st_reg.ctl[tbr_pkg::CTL_PIN_SEL] ? t8_level
			: port_out_i;
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// Everything freezes while the clock enable is low
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			st_reg <= '0;
			st_reg.ptr <= tbr_pkg::PTR_RST;
			st_reg.ctl <= tbr_pkg::CTL_RST;
			st_reg.t8_lo <= tbr_pkg::HOLD_RST;
			st_reg.t8_hi <= tbr_pkg::HOLD_RST;
			st_reg.t16_lo <= tbr_pkg::HOLD_RST;
			st_reg.t16_hi <= tbr_pkg::HOLD_RST;
			st_reg.c16_lo <= tbr_pkg::CAP_RST;
			st_reg.c16_hi <= tbr_pkg::CAP_RST;
			st_reg.c8_lo <= tbr_pkg::CAP_RST;
			st_reg.c8_hi <= tbr_pkg::CAP_RST;
		end
		else if (ce_i)
		begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------
	// Outputs, all straight from flip-flops
	// ----------------------------------------
	assign rdata_o = st_reg.rdata;
	assign hit_o = st_reg.hit;
	assign shared_pin_o = st_reg.pin;
	assign tout_irq_o = st_reg.tout_irq;
	assign cap_irq_o = st_reg.cap_irq;

endmodule

// ==== sim/tbr_bank_sva.sv ====
`timescale 1ns/1ps

module tbr_bank_sva (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	// Register access
	input wire tbr_pkg::tbr_req_s req_i,
	input wire logic [7:0] rdata_o,
	input wire logic hit_o,
	// Pins and requests
	input wire logic demod_mode_i,
	input wire logic demod_pin_i,
	input wire logic port_out_i,
	input wire logic shared_pin_o,
	input wire logic tout_irq_o,
	input wire logic cap_irq_o
);
	// ----------------------------------------
	// Shadow of pointer and control bits 2:0
	// ----------------------------------------
	logic [7:0] ptr_reg, ptr_next; // Bank pointer copy
	logic [2:0] cfg_reg, cfg_next; // Mask and pin select copy
	logic [7:0] eff; // Effective address
	logic acc; // Access taken this edge
	logic low; // Address in swapped group
	logic in_d; // Timer bank mapped

	// Decode as the block does, from the pointer before the edge
	always_comb
	begin
		eff = req_i.short_addr ? {ptr_reg[7:4], req_i.addr[3:0]} : req_i.addr;
		acc = ce_i && (req_i.wr || req_i.rd);
		low = eff[7:4] == tbr_pkg::GROUP_LOW;
		in_d = ptr_reg[3:0] == tbr_pkg::BANK_TIMER;
		ptr_next = ptr_reg;
		cfg_next = cfg_reg;
		if (acc && req_i.wr && eff == tbr_pkg::PTR_ADDR)
			ptr_next = req_i.wdata;
		if (acc && req_i.wr && low && in_d && eff[3:0] == tbr_pkg::OFS_CTL)
			cfg_next = req_i.wdata[2:0];
	end

	// Shadow registers
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			ptr_reg <= 8'h00;
			cfg_reg <= 3'h0;
		end
		else
		begin
			ptr_reg <= ptr_next;
			cfg_reg <= cfg_next;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);

	AST_HIT_CAUSE: assert property (hit_o |-> $past(acc))
		else $error("claim without access");
	AST_BANK_D_HIT: assert property (acc && low && in_d |=> hit_o)
		else $error("timer bank access not claimed");
	AST_BANK0_FREE: assert property (
		acc && low && ptr_reg[3:0] == 4'h0 |=> !hit_o)
		else $error("normal bank access claimed");
	AST_EMPTY_BANK: assert property (acc && req_i.rd && low &&
		!in_d && ptr_reg[3:0] != 4'h0 && ptr_reg[3:0] != 4'hF
		|=> hit_o && rdata_o == 8'h00)
		else $error("empty bank read wrong");
	AST_RSVD_ZERO: assert property (acc && req_i.rd && low && in_d &&
		eff[3:0] == tbr_pkg::OFS_RSVD |=> rdata_o == 8'h00)
		else $error("reserved read not zero");
	AST_PIN_PORT: assert property (!cfg_reg[0] && !$past(cfg_reg[0])
		|=> shared_pin_o == $past(port_out_i))
		else $error("shared pin not port output");
	AST_TOUT_MASK: assert property (!cfg_reg[1] && !$past(cfg_reg[1]) &&
		!$past(cfg_reg[1], 2) |-> !tout_irq_o)
		else $error("masked time-out request");
	AST_CAP_MASK: assert property (!cfg_reg[2] && !$past(cfg_reg[2]) &&
		!$past(cfg_reg[2], 2) |-> !cap_irq_o)
		else $error("masked capture request");
endmodule

bind tbr_bank tbr_bank_sva tbr_bank_sva_inst (.clk_i(clk_i),
	.sys_rst_i(sys_rst_i), .ce_i(ce_i), .req_i(req_i), .rdata_o(rdata_o),
	.hit_o(hit_o), .demod_mode_i(demod_mode_i), .demod_pin_i(demod_pin_i),
	.port_out_i(port_out_i), .shared_pin_o(shared_pin_o),
	.tout_irq_o(tout_irq_o), .cap_irq_o(cap_irq_o));

// ==== sim/tbr_bank_tb.sv ====
`timescale 1ns/1ps

module tbr_bank_tb;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clk_i = 1'b0; // 4 ns clock
	logic sys_rst_i = 1'b1; // Held at start
	logic ce_i = 1'b1; // High except during the clock-enable bank test
	tbr_pkg::tbr_req_s req_i = '0; // Idle bus
	logic demod_mode_i = 1'b0;
	logic demod_pin_i = 1'b0;
	logic port_out_i = 1'b0;
	logic [7:0] rdata_o;
	logic hit_o;
	logic shared_pin_o;
	logic tout_irq_o;
	logic cap_irq_o;
	logic [7:0] rd_v; // Last read data
	logic hit_v; // Last claim flag
	logic [7:0] keep; // Saved capture
	logic seen_hi; // Pin seen high
	int fails = 0;
	int checked = 0;
	int cyc = 0; // Hang guard
	int capn = 0; // Capture requests seen
	int n;
	int per[4]; // Time-out spacing per prescale code

	tbr_bank tbr_bank_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.ce_i(ce_i), .req_i(req_i), .rdata_o(rdata_o), .hit_o(hit_o),
		.demod_mode_i(demod_mode_i), .demod_pin_i(demod_pin_i),
		.port_out_i(port_out_i), .shared_pin_o(shared_pin_o),
		.tout_irq_o(tout_irq_o), .cap_irq_o(cap_irq_o));

	// Clock
	initial
		forever #2 clk_i = ~clk_i;

	// Hang guard and capture request count
	always @(negedge clk_i)
	begin
		cyc++;
		if (cap_irq_o === 1'b1)
			capn++;
		if (cyc == 20000)
		begin
			fails++;
			finish_test();
		end
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One access held for one edge; answer sampled a cycle later
	task automatic acc(input logic w, input logic s, input logic [7:0] a,
		input logic [7:0] d);
		@(negedge clk_i);
		req_i = '{wr: w, rd: !w, short_addr: s, addr: a, wdata: d};
		@(negedge clk_i);
		req_i = '0;
		rd_v = rdata_o;
		hit_v = hit_o;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		acc(1'b1, 1'b0, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		acc(1'b0, 1'b0, a, 8'h00);
		chk(rd_v, e);
	endtask

	// Bounded wait for a time-out request; 2000 means none came
	task automatic wait_tout(output int w);
		w = 0;
		@(negedge clk_i);
		while (tout_irq_o !== 1'b1 && w < 2000)
		begin
			@(negedge clk_i);
			w++;
		end
	endtask

	task automatic finish_test();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		repeat (16) @(negedge clk_i);
		sys_rst_i = 1'b0;
		wr(8'hFD, 8'h0D);
		for (int a = 0; a < 12; a++)
			rd(8'(a), 8'h00);
		for (int a = 4; a < 8; a++)
			wr(8'(a), 8'hA0 | 8'(a));
		for (int a = 4; a < 8; a++)
			rd(8'(a), 8'hA0 | 8'(a));
		wr(8'h03, 8'hFF);
		rd(8'h03, 8'h00);
		$display("register test done");
		// Bank selection and short addresses
		wr(8'hFD, 8'h00);
		acc(1'b0, 1'b0, 8'h04, 8'h00);
		chk(8'(hit_v), 8'h00);
		wr(8'hFD, 8'h05);
		rd(8'h04, 8'h00);
		chk(8'(hit_v), 8'h01);
		wr(8'hFD, 8'h7D);
		acc(1'b1, 1'b1, 8'h04, 8'h55);
		chk(8'(hit_v), 8'h00);
		wr(8'hFD, 8'h0D);
		acc(1'b0, 1'b1, 8'hF5, 8'h00);
		chk(rd_v, 8'hA5);
		rd(8'h04, 8'hA4);
		// Clock enable low: a write must not land; claim flag settles first
		@(negedge clk_i);
		ce_i = 1'b0;
		wr(8'h04, 8'h11);
		chk(8'(hit_v), 8'h00);
		ce_i = 1'b1;
		rd(8'h04, 8'hA4);
		$display("bank test done");
		// Timer run, prescale, flag and single pass
		wr(8'h04, 8'h03);
		wr(8'h05, 8'h03);
		wr(8'h00, 8'h82);
		rd(8'h00, 8'h82);
		for (int k = 0; k < 4; k++)
		begin
			wr(8'h00, 8'h82 | 8'(k << 3));
			wait_tout(n);
			wait_tout(n);
			per[k] = n + 1;
			chk(8'(per[k]), 8'h04 << k);
		end
		wr(8'h00, 8'h02);
		rd(8'h00, 8'h22);
		wr(8'h00, 8'h20);
		rd(8'h00, 8'h00);
		wr(8'h00, 8'hC2);
		wait_tout(n);
		rd(8'h00, 8'h62);
		wait_tout(n);
		chk(8'(n == 2000), 8'h01);
		wr(8'h00, 8'h20);
		$display("timer test done");
		// Shared pin source
		port_out_i = 1'b1;
		repeat (3) @(negedge clk_i);
		chk(8'(shared_pin_o), 8'h01);
		port_out_i = 1'b0;
		wr(8'h00, 8'h81);
		seen_hi = 1'b0;
		repeat (40)
		begin
			@(negedge clk_i);
			seen_hi = seen_hi | shared_pin_o;
		end
		chk(8'(seen_hi), 8'h01);
		wr(8'h00, 8'h20);
		$display("pin test done");
		// Demodulation capture, masking and read-only captures
		// Long slow high phase keeps the count falling, no wrap
		demod_mode_i = 1'b1;
		wr(8'h05, 8'h40);
		wr(8'h00, 8'h9C);
		for (int m = 0; m < 4; m++)
		begin
			if (m == 2)
				wr(8'h00, 8'h98);
			demod_pin_i = ~demod_pin_i;
			repeat (20) @(negedge clk_i);
		end
		chk(8'(capn), 8'h02);
		rd(8'h09, 8'h00);
		acc(1'b0, 1'b0, 8'h08, 8'h00);
		chk(8'(rd_v != 8'h00), 8'h01);
		// Rise came before fall, so the low capture holds the larger count
		acc(1'b0, 1'b0, 8'h0A, 8'h00);
		keep = rd_v;
		acc(1'b0, 1'b0, 8'h0B, 8'h00);
		chk(8'(keep > rd_v), 8'h01);
		for (int a = 8; a < 12; a++)
		begin
			acc(1'b0, 1'b0, 8'(a), 8'h00);
			keep = rd_v;
			wr(8'(a), ~keep);
			rd(8'(a), keep);
		end
		$display("capture test done");
		finish_test();
	end
endmodule
